// [core/cfm_mix_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - interrogate with coarse level sets coarse flip-flop; its output is the clamp
// - clamp commands the rate stage to the 12.8 kpps high rate
// - error selection samples on every 1600 pps interrogate pulse
// - inhibit from the alternate sync stage masks alternate coarse interrogations
// - inhibit rises at phase-3 time after the first detecting interrogate
// - inhibit falls at phase-3 time after the second interrogate
// - coarse flip-flop changes only on interrogates seen without inhibit
// - selected error carries the phase of the detected ternary level
// - clamp holds while coarse persists and blocks the fine level
// - each level is detected by ANDing it with the interrogate pulse
// - only one level passes; coarse first, fine otherwise
// - selected error drives counter direction and rate until nulled
// - alternate sync uses two flip-flops: the first set at phase-2 and cleared by detection, the second loaded at phase-3
// - phase pulses are the first phase-2 and phase-3 times after interrogate
// - on third and alternate pulses the inhibit sequence repeats
module cfm_mix_top
  import cfm_pkg::*;
#(
  parameter int unsigned INT_PERIOD_CYCLES = cfm_pkg::INTERROGATE_CYCLES
)(
  // clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RESETN,
  // converter timing pulses
  input  wire logic INTERROGATE,
  input  wire logic PHASE_TWO_TIME,
  input  wire logic PHASE_THREE_TIME,
  // ternary levels from the conversion system
  input  wire logic COARSE_TERNARY_LEVEL,
  input  wire logic COARSE_TERNARY_PHASE,
  input  wire logic FINE_TERNARY_LEVEL,
  input  wire logic FINE_TERNARY_PHASE,
  // to counter direction and rate stages
  output logic      SELECTED_ERROR,
  output logic      SELECTED_ERROR_PHASE,
  output logic      COARSE_HOLD_CLAMP,
  output logic      HIGH_RATE_CMD,
  output logic      ALT_INHIBIT
);

  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_q;
  logic [2:0]       pulse_prev_q;
  logic             int_p;
  logic             coarse_on;
  logic             coarse_ph;
  logic             fine_on;
  logic             fine_ph;
  logic             coarse_hit;
  logic             fine_hit;
  logic             clamp_q;
  logic             sel_valid_q;
  logic             sel_phase_q;
  logic [1:0]       int_since_det_q;
  logic             ph2_seen_q;
  logic             ph3_seen_q;

  cfm_tick_if tick ();

  function automatic logic rise(input logic now, input logic prev);
    return now && !prev;
  endfunction

  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // every pin is asynchronous to the core clock
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= PIN_RST;
      pin_q      <= PIN_RST;
    end else begin
      pin_meta_q <= {FINE_TERNARY_PHASE, FINE_TERNARY_LEVEL, COARSE_TERNARY_PHASE,
                     COARSE_TERNARY_LEVEL, PHASE_THREE_TIME, PHASE_TWO_TIME, INTERROGATE};
      pin_q      <= pin_meta_q;
    end
  end

  // edge detect on the second stage only
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pulse_prev_q <= 3'h0;
    end else begin
      pulse_prev_q <= pin_q[PIN_PH3:PIN_INT];
    end
  end

  assign int_p                 = rise(pin_q[PIN_INT], pulse_prev_q[0]);
  assign tick.interrogate      = int_p;
  assign tick.phase_two_tick   = rise(pin_q[PIN_PH2], pulse_prev_q[1]);
  assign tick.phase_three_tick = rise(pin_q[PIN_PH3], pulse_prev_q[2]);
  assign coarse_on             = pin_q[PIN_C_ON];
  assign coarse_ph             = pin_q[PIN_C_PH];
  assign fine_on               = pin_q[PIN_F_ON];
  assign fine_ph               = pin_q[PIN_F_PH];

  // level detection is a plain AND with the interrogate pulse
  assign coarse_hit = int_p && coarse_on;
  assign fine_hit   = int_p && fine_on;

  // masked pulses neither detect nor reach the alternate sync stage
  assign tick.coarse_detect = coarse_hit && !tick.alt_inhibit;

  cfm_phase_gen u_phase_gen (
    .clk  (CORE_CLK),
    .rst_n(rst_n),
    .tick (tick)
  );

  cfm_alt_sync u_alt_sync (
    .clk  (CORE_CLK),
    .rst_n(rst_n),
    .tick (tick)
  );

  // coarse select flip-flop, sampled only on unmasked interrogates
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clamp_q <= CLAMP_RST;
    end else if (int_p && !tick.alt_inhibit) begin
      clamp_q <= coarse_on;
    end
  end

  // selected error: coarse wins; the clamp keeps fine out even on masked pulses
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_valid_q <= SEL_VALID_RST;
      sel_phase_q <= SEL_PHASE_RST;
    end else if (int_p) begin
      if (coarse_hit) begin
        sel_valid_q <= 1'b1;
        sel_phase_q <= coarse_ph;
      end else if (fine_hit && !clamp_q) begin
        sel_valid_q <= 1'b1;
        sel_phase_q <= fine_ph;
      end else begin
        sel_valid_q <= 1'b0;
        sel_phase_q <= SEL_PHASE_RST;
      end
    end
  end

  // helper for the assertions: interrogates since the last detection
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      int_since_det_q <= 2'h0;
    end else if (tick.coarse_detect) begin
      int_since_det_q <= 2'h1;
    end else if (int_p && int_since_det_q != 2'h3) begin
      int_since_det_q <= int_since_det_q + 2'h1;
    end
  end

  // helper for the assertions: phase pulses taken since the last interrogate
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ph2_seen_q <= 1'b0;
      ph3_seen_q <= 1'b0;
    end else if (int_p) begin
      ph2_seen_q <= 1'b0;
      ph3_seen_q <= 1'b0;
    end else begin
      if (tick.phase_two_interrogate) begin
        ph2_seen_q <= 1'b1;
      end
      if (tick.phase_three_interrogate) begin
        ph3_seen_q <= 1'b1;
      end
    end
  end

  // error stays until a later interrogate nulls it
  assign SELECTED_ERROR       = sel_valid_q;
  assign SELECTED_ERROR_PHASE = sel_phase_q;
  assign COARSE_HOLD_CLAMP    = clamp_q;
  // a level, not a pulse train: the rate stage makes the 12.8 kpps pulses
  assign HIGH_RATE_CMD        = clamp_q;
  assign ALT_INHIBIT          = tick.alt_inhibit;

  a_clamp_on_detect: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick.coarse_detect |=> clamp_q)
    else $error("coarse detection did not set the clamp");

  a_high_rate_hold: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    clamp_q && !int_p |=> HIGH_RATE_CMD && COARSE_HOLD_CLAMP)
    else $error("high rate command dropped between interrogates");

  a_sample_only_int: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    !int_p |=> $stable(sel_valid_q) && $stable(sel_phase_q))
    else $error("selected error changed without interrogate");

  a_masked_no_detect: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick.coarse_detect |-> !tick.alt_inhibit && int_p && coarse_on)
    else $error("detection reported on a masked pulse");

  a_inhibit_rise: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    $rose(tick.alt_inhibit) |-> $past(tick.phase_three_interrogate)
      && int_since_det_q == 2'h1)
    else $error("inhibit rose at the wrong time");

  a_inhibit_fall: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    $fell(tick.alt_inhibit) |-> $past(tick.phase_three_interrogate)
      && int_since_det_q == 2'h2)
    else $error("inhibit fell at the wrong time");

  a_masked_clamp: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && tick.alt_inhibit |=> $stable(clamp_q))
    else $error("coarse flip-flop changed while inhibited");

  a_coarse_phase: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    coarse_hit |=> SELECTED_ERROR && SELECTED_ERROR_PHASE == $past(coarse_ph))
    else $error("selected error lost the coarse phase");

  a_fine_blocked: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && clamp_q && !coarse_on |=> !SELECTED_ERROR)
    else $error("fine level passed under the clamp");

  a_fine_phase: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    fine_hit && !coarse_on && !clamp_q |=> SELECTED_ERROR
      && SELECTED_ERROR_PHASE == $past(fine_ph))
    else $error("selected error lost the fine phase");

  a_masked_no_clear: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick.alt_inhibit |-> int_since_det_q != 2'h0 && int_since_det_q != 2'h3)
    else $error("inhibit outside the two-pulse window");

  a_idle_no_error: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && !coarse_on && !fine_on |=> !SELECTED_ERROR ##1 !SELECTED_ERROR || $past(int_p))
    else $error("error reported with no level present");

  a_masked_one_pulse: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && tick.alt_inhibit |-> int_since_det_q == 2'h1)
    else $error("inhibit masked other than the second interrogate");

  a_inhibit_on_ph3: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    $changed(tick.alt_inhibit) |-> $past(tick.phase_three_interrogate))
    else $error("inhibit changed away from phase-3 time");

  a_clamp_steady: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    !int_p |=> $stable(clamp_q))
    else $error("clamp moved between interrogates");

  a_clamp_follows: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && !tick.alt_inhibit |=> clamp_q == $past(coarse_on))
    else $error("coarse flip-flop missed an open interrogate");

  a_rate_on_detect: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick.coarse_detect |=> HIGH_RATE_CMD)
    else $error("high rate not commanded on coarse detection");

  a_rate_off: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && !tick.alt_inhibit && !coarse_on |=> !HIGH_RATE_CMD)
    else $error("high rate kept with coarse level gone");

  a_fine_ignored: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && coarse_on && fine_on |=> SELECTED_ERROR_PHASE == $past(coarse_ph))
    else $error("fine phase passed while coarse present");

  a_no_fine_masked: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && tick.alt_inhibit && !coarse_on |=> !SELECTED_ERROR)
    else $error("fine level passed on a masked interrogate");

  a_error_on_level: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && (coarse_on || (fine_on && !clamp_q)) |=> SELECTED_ERROR)
    else $error("level present but no selected error");

  a_idle_phase_low: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    !SELECTED_ERROR |-> !SELECTED_ERROR_PHASE)
    else $error("error phase set with no error");

  a_third_detects: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    int_p && coarse_on && int_since_det_q == 2'h2 |-> tick.coarse_detect)
    else $error("third interrogate did not detect coarse level");

  a_ph2_once: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick.phase_two_interrogate |-> !ph2_seen_q && !ph3_seen_q)
    else $error("second phase-2 pulse taken after one interrogate");

  a_ph3_order: assert property (
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick.phase_three_interrogate |-> ph2_seen_q && !ph3_seen_q)
    else $error("phase-3 pulse taken out of order");

endmodule

// [core/cfm_pkg.sv]
package cfm_pkg;

  // core clock
  localparam int unsigned CORE_CLK_HZ        = 20_000_000;

  // converter rates, figures as printed
  localparam int unsigned INTERROGATE_PPS    = 1600;
  localparam int unsigned TERNARY_CPS        = 800;
  localparam int unsigned HIGH_RATE_PPS      = 12800;

  // periods in core cycles, rounded down
  localparam int unsigned INTERROGATE_CYCLES = CORE_CLK_HZ / INTERROGATE_PPS;
  localparam int unsigned TERNARY_CYCLES     = CORE_CLK_HZ / TERNARY_CPS;
  localparam int unsigned HIGH_RATE_CYCLES   = CORE_CLK_HZ / HIGH_RATE_PPS;

  // synchroniser depth and pin bundle layout
  localparam int unsigned SYNC_STAGES        = 2;
  localparam int unsigned PIN_W              = 7;
  localparam int unsigned PIN_INT            = 0;
  localparam int unsigned PIN_PH2            = 1;
  localparam int unsigned PIN_PH3            = 2;
  localparam int unsigned PIN_C_ON           = 3;
  localparam int unsigned PIN_C_PH           = 4;
  localparam int unsigned PIN_F_ON           = 5;
  localparam int unsigned PIN_F_PH           = 6;

  // values after reset
  localparam logic             CLAMP_RST     = 1'b0;
  localparam logic             SEL_VALID_RST = 1'b0;
  localparam logic             SEL_PHASE_RST = 1'b0;
  localparam logic             ARM_FF_RST    = 1'b1;
  localparam logic             HOLD_FF_RST   = 1'b1;
  localparam logic [PIN_W-1:0] PIN_RST       = 7'h00;

  // phase pulse generator states
  typedef enum logic [1:0] {
    CFM_IDLE     = 2'b00,
    CFM_WAIT_PH2 = 2'b01,
    CFM_WAIT_PH3 = 2'b11
  } cfm_phase_state_t;

endpackage

// [core/cfm_tick_if.sv]
`timescale 1ns/1ps
interface cfm_tick_if;
  logic interrogate;
  logic phase_two_tick;
  logic phase_three_tick;
  logic phase_two_interrogate;
  logic phase_three_interrogate;
  logic coarse_detect;
  logic alt_inhibit;

  modport core (
    output interrogate,
    output phase_two_tick,
    output phase_three_tick,
    output coarse_detect,
    input  phase_two_interrogate,
    input  phase_three_interrogate,
    input  alt_inhibit
  );

  modport phase_gen (
    input  interrogate,
    input  phase_two_tick,
    input  phase_three_tick,
    output phase_two_interrogate,
    output phase_three_interrogate
  );

  modport alt_sync (
    input  phase_two_interrogate,
    input  phase_three_interrogate,
    input  coarse_detect,
    output alt_inhibit
  );
endinterface

// [core/cfm_phase_gen.sv]
`timescale 1ns/1ps
module cfm_phase_gen
  import cfm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing
  cfm_tick_if.phase_gen tick
);

  cfm_phase_state_t state_q;
  cfm_phase_state_t state_d;

  // a new interrogate restarts the sequence so each pair follows its own pulse
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CFM_IDLE: begin
        if (tick.interrogate) begin
          state_d = CFM_WAIT_PH2;
        end
      end
      CFM_WAIT_PH2: begin
        if (tick.phase_two_tick) begin
          state_d = CFM_WAIT_PH3;
        end
      end
      CFM_WAIT_PH3: begin
        if (tick.phase_three_tick) begin
          state_d = CFM_IDLE;
        end
      end
      default: begin
        state_d = CFM_IDLE;
      end
    endcase
    if (tick.interrogate) begin
      state_d = CFM_WAIT_PH2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CFM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // first phase-2 and phase-3 times after each interrogate
  assign tick.phase_two_interrogate   = (state_q == CFM_WAIT_PH2) && tick.phase_two_tick;
  assign tick.phase_three_interrogate = (state_q == CFM_WAIT_PH3) && tick.phase_three_tick;

  a_ph3_after_ph2: assert property (
    @(posedge clk) disable iff (!rst_n)
    tick.phase_three_interrogate |-> state_q == CFM_WAIT_PH3 ##1 state_q != CFM_WAIT_PH3
      || tick.interrogate)
    else $error("phase-3 interrogate outside its slot");

endmodule

// [core/cfm_alt_sync.sv]
`timescale 1ns/1ps
module cfm_alt_sync
  import cfm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing and detection
  cfm_tick_if.alt_sync tick
);

  logic arm_q;
  logic hold_q;

  // first stage: cleared by detection, set again at phase-2 of the masked pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= ARM_FF_RST;
    end else if (tick.coarse_detect) begin
      arm_q <= 1'b0;
    end else if (tick.phase_two_interrogate && !hold_q) begin
      arm_q <= 1'b1;
    end
  end

  // second stage: follows the first at phase-3 time; low means inhibit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= HOLD_FF_RST;
    end else if (tick.phase_three_interrogate) begin
      hold_q <= arm_q;
    end
  end

  assign tick.alt_inhibit = !hold_q;

  a_arm_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    tick.coarse_detect |=> !arm_q)
    else $error("detection did not clear first stage");

endmodule

// [test/cfm_conv_model.sv]
`timescale 1ns/1ps
module cfm_conv_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // frame request from the bench
  input  wire logic fire,
  // timing pins toward the mix logic, and busy toward the bench
  output logic      int_pin,
  output logic      ph2_pin,
  output logic      ph3_pin,
  output logic      busy
);
  logic [3:0] cnt_q;

  // one frame: interrogate, then first phase-2, then first phase-3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= (cnt_q == 4'hc) ? 4'h0 : cnt_q + 4'h1;
    end else if (fire) begin
      cnt_q <= 4'h1;
    end
  end

  // two cycles high and two low, wider than the synchroniser needs
  assign int_pin = (cnt_q == 4'h1) || (cnt_q == 4'h2);
  assign ph2_pin = (cnt_q == 4'h5) || (cnt_q == 4'h6);
  assign ph3_pin = (cnt_q == 4'h9) || (cnt_q == 4'ha);
  assign busy    = (cnt_q != 4'h0);
endmodule

// [test/test_coarse_fine_error_select.sv]
`timescale 1ns/1ps
module test_coarse_fine_error_select;
  logic clk;
  logic rst_n;
  logic fire;
  logic c_on;
  logic c_ph;
  logic f_on;
  logic f_ph;
  logic int_pin;
  logic ph2_pin;
  logic ph3_pin;
  logic busy;
  logic sel;
  logic sel_ph;
  logic clamp;
  logic high;
  logic inh;
  int   miscompares = 0;
  int   checks      = 0;
  int   cycles      = 0;

  cfm_mix_top #(.INT_PERIOD_CYCLES(16)) cfm_mix_top_i (
    .CORE_CLK             (clk),
    .RESETN               (rst_n),
    .INTERROGATE          (int_pin),
    .PHASE_TWO_TIME       (ph2_pin),
    .PHASE_THREE_TIME     (ph3_pin),
    .COARSE_TERNARY_LEVEL (c_on),
    .COARSE_TERNARY_PHASE (c_ph),
    .FINE_TERNARY_LEVEL   (f_on),
    .FINE_TERNARY_PHASE   (f_ph),
    .SELECTED_ERROR       (sel),
    .SELECTED_ERROR_PHASE (sel_ph),
    .COARSE_HOLD_CLAMP    (clamp),
    .HIGH_RATE_CMD        (high),
    .ALT_INHIBIT          (inh)
  );

  cfm_conv_model cfm_conv_model_i (
    .clk     (clk),
    .rst_n   (rst_n),
    .fire    (fire),
    .int_pin (int_pin),
    .ph2_pin (ph2_pin),
    .ph3_pin (ph3_pin),
    .busy    (busy)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a stalled run is stopped after 4000 cycles; the frame wait gives up after 40 on its own
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic expect_out(input logic e_sel, input logic e_ph, input logic e_clamp,
                            input logic e_inh);
    check1(sel, e_sel);
    check1(sel_ph, e_ph);
    check1(clamp, e_clamp);
    check1(high, e_clamp);
    check1(inh, e_inh);
  endtask

  // levels set one cycle ahead of the interrogate pin, held over the frame
  task automatic frame(input logic co, input logic cp, input logic fo, input logic fp);
    int n;
    n = 0;
    @(posedge clk);
    c_on <= co;
    c_ph <= cp;
    f_on <= fo;
    f_ph <= fp;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(negedge clk);
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, busy, 1'b0);
    end
    repeat (5) @(negedge clk);
  endtask

  task automatic sc_fine;
    frame(1'b0, 1'b0, 1'b1, 1'b1);
    expect_out(1'b1, 1'b1, 1'b0, 1'b0);
    frame(1'b0, 1'b0, 1'b1, 1'b0);
    expect_out(1'b1, 1'b0, 1'b0, 1'b0);
    frame(1'b0, 1'b1, 1'b0, 1'b1);
    expect_out(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic sc_coarse_alt;
    frame(1'b1, 1'b1, 1'b1, 1'b0);
    expect_out(1'b1, 1'b1, 1'b1, 1'b1);
    frame(1'b0, 1'b0, 1'b1, 1'b0);
    expect_out(1'b0, 1'b0, 1'b1, 1'b0);
    frame(1'b0, 1'b0, 1'b1, 1'b0);
    check1(clamp, 1'b0);
    check1(inh, 1'b0);
    frame(1'b0, 1'b0, 1'b1, 1'b1);
    expect_out(1'b1, 1'b1, 1'b0, 1'b0);
  endtask

  // clamp and inhibit both set when reset strikes mid-run
  task automatic sc_coarse_repeat;
    frame(1'b1, 1'b0, 1'b0, 1'b0);
    expect_out(1'b1, 1'b0, 1'b1, 1'b1);
    frame(1'b1, 1'b1, 1'b1, 1'b0);
    expect_out(1'b1, 1'b1, 1'b1, 1'b0);
    frame(1'b1, 1'b1, 1'b0, 1'b0);
    expect_out(1'b1, 1'b1, 1'b1, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    c_on  <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    expect_out(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    frame(1'b0, 1'b0, 1'b0, 1'b0);
    expect_out(1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    fire  = 1'b0;
    c_on  = 1'b0;
    c_ph  = 1'b0;
    f_on  = 1'b0;
    f_ph  = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    sc_fine();
    sc_coarse_alt();
    sc_coarse_repeat();
    conclude();
  end
endmodule
